//--- rtl/ppw_pkg.sv
// Purpose: shared constants and types for the page pointer list walker
// Assumes: 64-bit host addresses, page size from 4 KiB upward
// Notes:   page size setting n gives a page of 2^(12+n) bytes
`default_nettype none
package ppw_pkg;
  // =====================================================================
  // widths and encodings
  localparam int unsigned ADDR_W      = 64;
  localparam int unsigned LEN_W       = 32;
  localparam int unsigned MPS_W       = 4;
  localparam int unsigned PAGE_SHIFT0 = 12;
  localparam int unsigned ENTRY_BYTES = 8;
  localparam int unsigned ENTRY_SHIFT = 3;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 64'h0000_0000_0000_0000;
  localparam logic [LEN_W-1:0]  LEN_ZERO  = 32'h0000_0000;
  localparam logic [1:0]        DW_MASK   = 2'h3;
  localparam logic [2:0]        QW_MASK   = 3'h7;
  localparam logic              CHECK_DW_RESET = 1'b1;

  typedef enum logic [1:0] {
    PPW_ERR_NONE,
    PPW_ERR_BAD_OFFSET,
    PPW_ERR_BAD_LIST_PTR
  } ppw_err_t;
endpackage : ppw_pkg
`default_nettype wire

//--- rtl/ppw_page_calc.sv
// Purpose: page base and offset split of one page pointer entry
// Assumes: memory_page_size_setting is stable during a command
// Notes:   purely combinational, split used for the first entry; page size used throughout
`default_nettype none
module ppw_page_calc
  import ppw_pkg::*;
(
  // configuration
  input  wire logic [MPS_W-1:0]  memory_page_size_setting,
  // entry under test
  input  wire logic [ADDR_W-1:0] page_base_and_offset,
  // results
  output logic      [ADDR_W-1:0] page_base,
  output logic      [ADDR_W-1:0] page_offset,
  output logic      [ADDR_W-1:0] page_bytes
);
  // =====================================================================
  // offset mask from page size, 4 KiB gives bits 11:0
  logic [ADDR_W-1:0] off_mask;
  always_comb begin
    page_bytes  = ADDR_W'(1) << (PAGE_SHIFT0 + 32'(memory_page_size_setting)); // [R02]
    off_mask    = page_bytes - ADDR_W'(1);
    page_offset = page_base_and_offset & off_mask; // [R01]
    page_base   = page_base_and_offset & ~off_mask; // [R01]
  end
endmodule : ppw_page_calc
`default_nettype wire

//--- rtl/ppw_walker.sv
// Purpose: walks page pointer entries and lists, emits data segments
// Assumes: one outstanding list fetch at a time, host memory answers reads
// Notes:   segments come out in order; entries are fixed size so order is free
`default_nettype none
// Operation
// R01: entry is 64-bit address, base plus offset
// R02: offset width follows configured page size
// R03: host zeroes offsets of non-first entries
// R04: host keeps offsets dword aligned
// R05: low two bits flagged or treated zero
// R06: fixed size entries, pages fetchable out-of-order
// R07: list is one page, no duplicates
// R08: last list slot chains to next page
// R09: first data entry may carry an offset
// R10: list pointer qword aligned, offset honoured
// R11: host zeroes offsets of list entries
// R12: host zeroes offset of second entry
// R13: nonzero offset there ends with error
// R14: host packs lists from index zero
// R15: host aligns chained list pages
// R16: entry count derived from length, page
// R17: second slot data if rest fits page
// R18: slots per list page less offset
module ppw_walker
  import ppw_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // configuration
  input  wire logic [MPS_W-1:0]  memory_page_size_setting,
  input  wire logic              check_dword_align,
  // command
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic [ADDR_W-1:0] first_command_pointer,
  input  wire logic [ADDR_W-1:0] second_command_pointer_slot,
  input  wire logic [LEN_W-1:0]  xfer_bytes,
  // list entry fetch from host memory
  output logic                   fetch_valid,
  input  wire logic              fetch_ready,
  output logic      [ADDR_W-1:0] fetch_addr,
  input  wire logic              entry_valid,
  input  wire logic [ADDR_W-1:0] entry_data,
  // data segments out
  output logic                   seg_valid,
  input  wire logic              seg_ready,
  output logic      [ADDR_W-1:0] seg_addr,
  output logic      [LEN_W-1:0]  seg_len,
  output logic                   seg_last,
  // completion
  output logic                   done,
  output logic                   bad_page_offset_error,
  output ppw_err_t               err_code
);
  // =====================================================================
  // state
  typedef enum logic [2:0] {
    PPW_IDLE, PPW_FIRST, PPW_SECOND, PPW_FETCH, PPW_WAIT, PPW_EMIT, PPW_DONE
  } ppw_state_t;

  ppw_state_t        state_reg;
  logic [LEN_W-1:0]  remain_reg;
  logic [ADDR_W-1:0] list_addr_reg;
  logic [ADDR_W-1:0] cur_entry_reg;
  logic [ADDR_W-1:0] slots_left_reg;
  logic [ADDR_W-1:0] seg_addr_reg;
  logic [LEN_W-1:0]  seg_len_reg;
  logic              seg_last_reg;
  logic              done_reg;
  logic              err_reg;
  ppw_err_t          err_code_reg;
  logic [ADDR_W-1:0] p2_reg;

  // =====================================================================
  // entry split; its base and offset are used for the first entry only, page size for all
  logic [ADDR_W-1:0] calc_in;
  logic [ADDR_W-1:0] calc_base;
  logic [ADDR_W-1:0] calc_off;
  logic [ADDR_W-1:0] page_bytes;

  // first pointer is latched at accept, so the input may move once taken
  always_comb begin
    calc_in = cur_entry_reg;
  end

  ppw_page_calc u_calc (
    .memory_page_size_setting (memory_page_size_setting),
    .page_base_and_offset     (calc_in),
    .page_base                (calc_base),
    .page_offset              (calc_off),
    .page_bytes               (page_bytes)
  );

  // =====================================================================
  // per-entry segment sizing
  logic [ADDR_W-1:0] off_eff;
  logic [ADDR_W-1:0] room;
  logic [LEN_W-1:0]  take;
  logic              dw_bad;
  logic              fits_one;
  logic [ADDR_W-1:0] list_off;
  logic [ADDR_W-1:0] list_slots;

  always_comb begin
    dw_bad  = check_dword_align && ((calc_off[1:0] & DW_MASK) != 2'h0); // [R05]
    off_eff = {calc_off[ADDR_W-1:2], 2'h0}; // [R05] low bits taken as zero
    room    = page_bytes - off_eff; // [R09]
    take    = (ADDR_W'(remain_reg) > room) ? LEN_W'(room) : remain_reg; // [R16]
    fits_one = ADDR_W'(remain_reg) <= page_bytes; // [R17]
    list_off   = p2_reg & (page_bytes - ADDR_W'(1)); // [R10]
    list_slots = (page_bytes - list_off) >> ENTRY_SHIFT; // [R18]
  end

  // =====================================================================
  // walk sequencer; fixed entry size lets slot address be index times eight
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= PPW_IDLE;
      remain_reg     <= LEN_ZERO;
      list_addr_reg  <= ADDR_ZERO;
      cur_entry_reg  <= ADDR_ZERO;
      slots_left_reg <= ADDR_ZERO;
      p2_reg         <= ADDR_ZERO;
      seg_addr_reg   <= ADDR_ZERO;
      seg_len_reg    <= LEN_ZERO;
      seg_last_reg   <= 1'b0;
      done_reg       <= 1'b0;
      err_reg        <= 1'b0;
      err_code_reg   <= PPW_ERR_NONE;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        PPW_IDLE: begin
          if (cmd_valid) begin
            remain_reg   <= xfer_bytes; // [R16]
            cur_entry_reg  <= first_command_pointer; // [R09]
            slots_left_reg <= ADDR_ZERO; // no list walk left over from the last command
            p2_reg       <= second_command_pointer_slot;
            err_reg      <= 1'b0;
            err_code_reg <= PPW_ERR_NONE;
            state_reg    <= (xfer_bytes == LEN_ZERO) ? PPW_DONE : PPW_FIRST;
          end
        end
        PPW_FIRST: begin
          // first entry may start mid-page
          if (dw_bad) begin
            err_reg      <= 1'b1; // [R05]
            err_code_reg <= PPW_ERR_BAD_OFFSET;
            state_reg    <= PPW_DONE;
          end else begin
            seg_addr_reg <= calc_base | off_eff; // [R09]
            seg_len_reg  <= take;
            seg_last_reg <= (take == remain_reg);
            remain_reg   <= remain_reg - take;
            state_reg    <= PPW_EMIT;
          end
        end
        PPW_SECOND: begin
          if (fits_one) begin
            cur_entry_reg <= p2_reg; // [R17] direct data page
            slots_left_reg <= ADDR_ZERO;
            state_reg     <= PPW_EMIT;
            seg_valid_load(p2_reg);
          end else if ((p2_reg[2:0] & QW_MASK) != 3'h0) begin
            err_reg      <= 1'b1; // [R10]
            err_code_reg <= PPW_ERR_BAD_LIST_PTR;
            state_reg    <= PPW_DONE;
          end else begin
            list_addr_reg  <= p2_reg; // [R10] list starts at its offset
            slots_left_reg <= list_slots; // [R18]
            state_reg      <= PPW_FETCH;
          end
        end
        PPW_FETCH: begin
          if (fetch_ready) begin
            state_reg <= PPW_WAIT;
          end
        end
        PPW_WAIT: begin
          if (entry_valid) begin
            if ((slots_left_reg == ADDR_W'(1)) && !fits_one) begin
              // last slot holds the next list page, not data
              list_addr_reg  <= entry_data; // [R08] [R07]
              slots_left_reg <= page_bytes >> ENTRY_SHIFT;
              state_reg      <= PPW_FETCH;
            end else begin
              cur_entry_reg  <= entry_data;
              list_addr_reg  <= list_addr_reg + ADDR_W'(ENTRY_BYTES); // [R06]
              slots_left_reg <= slots_left_reg - ADDR_W'(1);
              state_reg      <= PPW_SECOND;
              seg_valid_load(entry_data);
            end
          end
        end
        PPW_EMIT: begin
          if (seg_ready) begin
            if (seg_last_reg || err_reg) begin
              state_reg <= PPW_DONE;
            end else if (slots_left_reg != ADDR_ZERO) begin
              state_reg <= PPW_FETCH;
            end else begin
              state_reg <= PPW_SECOND;
            end
          end
        end
        PPW_DONE: begin
          done_reg  <= 1'b1;
          state_reg <= PPW_IDLE;
        end
        default: begin
          state_reg <= PPW_IDLE;
        end
      endcase
    end
  end

  // =====================================================================
  // loads a segment of up to one page from a later entry, checking its offset
  task automatic seg_valid_load(input logic [ADDR_W-1:0] ent);
    logic [ADDR_W-1:0] off;
    logic [LEN_W-1:0]  n;
    off = ent & (page_bytes - ADDR_W'(1));
    n   = (ADDR_W'(remain_reg) > page_bytes) ? LEN_W'(page_bytes) : remain_reg;
    if (off != ADDR_ZERO) begin
      err_reg      <= 1'b1; // [R13]
      err_code_reg <= PPW_ERR_BAD_OFFSET;
      state_reg    <= PPW_DONE;
    end else begin
      seg_addr_reg <= ent;
      seg_len_reg  <= n;
      seg_last_reg <= (n == remain_reg);
      remain_reg   <= remain_reg - n;
      state_reg    <= PPW_EMIT;
    end
  endtask : seg_valid_load

  // =====================================================================
  // outputs; segment fields are registers, handshakes decode state
  always_comb begin
    cmd_ready   = (state_reg == PPW_IDLE);
    fetch_valid = (state_reg == PPW_FETCH);
    seg_valid   = (state_reg == PPW_EMIT);
  end

  assign fetch_addr            = list_addr_reg;
  assign seg_addr              = seg_addr_reg;
  assign seg_len               = seg_len_reg;
  assign seg_last              = seg_last_reg;
  assign done                  = done_reg;
  assign bad_page_offset_error = err_reg;
  assign err_code              = err_code_reg;
endmodule : ppw_walker
`default_nettype wire

//--- dv/ppw_walker_assertions.sv
// Purpose: port checker for ppw_walker
// Assumes: one clock domain, async active-low reset
// Notes:   bound to every walker instance
`default_nettype none
module ppw_walker_chk
  import ppw_pkg::*;
(
  // watched ports
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic [MPS_W-1:0]  memory_page_size_setting,
  input wire logic              check_dword_align,
  input wire logic              cmd_valid,
  input wire logic              cmd_ready,
  input wire logic [ADDR_W-1:0] first_command_pointer,
  input wire logic [LEN_W-1:0]  xfer_bytes,
  input wire logic              fetch_valid,
  input wire logic              fetch_ready,
  input wire logic [ADDR_W-1:0] fetch_addr,
  input wire logic              seg_valid,
  input wire logic              seg_ready,
  input wire logic [ADDR_W-1:0] seg_addr,
  input wire logic [LEN_W-1:0]  seg_len,
  input wire logic              done,
  input wire logic              bad_page_offset_error,
  input wire ppw_err_t          err_code
);
  // ====================================================================
  // helpers
  wire logic         acc;
  logic [ADDR_W-1:0] pmask;
  logic              first_q;
  assign acc = cmd_valid && cmd_ready;
  assign pmask = (64'h1 << (PAGE_SHIFT0 + memory_page_size_setting)) - 64'h1;
  // marks the first segment, the only one allowed an in-page offset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) first_q <= 1'b0;
    else if (acc) first_q <= 1'b1;
    else if (seg_valid && seg_ready) first_q <= 1'b0;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_done_pulse: assert property (done |=> !done) else $error("done too long");
  a_ready_back: assert property (done |-> cmd_ready) else $error("no ready with done");
  a_busy_cmd: assert property (acc |=> !cmd_ready) else $error("ready while busy");
  a_first_seg: assert property (acc && xfer_bytes != LEN_ZERO
    && !(check_dword_align && first_command_pointer[1:0] != 2'h0) |-> ##2 seg_valid)
    else $error("first segment late");
  a_seg_hold: assert property (seg_valid && !seg_ready |=> seg_valid
    && $stable(seg_addr) && $stable(seg_len)) else $error("segment dropped");
  a_fetch_hold: assert property (fetch_valid && !fetch_ready |=> fetch_valid
    && $stable(fetch_addr)) else $error("fetch dropped");
  a_list_qword: assert property (fetch_valid |-> fetch_addr[2:0] == 3'h0)
    else $error("fetch not qword aligned");
  a_seg_in_page: assert property (seg_valid |->
    (seg_addr & pmask) + {32'h0, seg_len} <= pmask + 64'h1) else $error("crosses page");
  a_later_aligned: assert property (seg_valid && !first_q |->
    (seg_addr & pmask) == ADDR_ZERO) else $error("later segment offset");
  a_first_dword: assert property (seg_valid && first_q |-> seg_addr[1:0] == 2'h0)
    else $error("low bits kept");
  a_dword_flag: assert property (acc && check_dword_align && xfer_bytes != LEN_ZERO
    && first_command_pointer[1:0] != 2'h0 |-> ##[1:4] (done && bad_page_offset_error))
    else $error("dword error missing");
  a_zero_len: assert property (acc && xfer_bytes == LEN_ZERO |=>
    !seg_valid throughout ##[0:3] (done && !bad_page_offset_error)) else $error("zero len");
  a_err_code: assert property (done |-> bad_page_offset_error == (err_code != PPW_ERR_NONE))
    else $error("flag and code differ");
endmodule : ppw_walker_chk
bind ppw_walker ppw_walker_chk u_chk (.mclk, .rst_n, .memory_page_size_setting,
  .check_dword_align, .cmd_valid, .cmd_ready, .first_command_pointer, .xfer_bytes,
  .fetch_valid, .fetch_ready, .fetch_addr, .seg_valid, .seg_ready, .seg_addr, .seg_len,
  .done, .bad_page_offset_error, .err_code);
`default_nettype wire

//--- dv/ppw_host_mem.sv
// Purpose: host memory answering list entry fetches
// Assumes: bench fills mem before each command
// Notes:   answers two to four cycles after a fetch is taken, ready stalls at random
`default_nettype none
module ppw_host_mem
  import ppw_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // fetch side
  input  wire logic              fetch_valid,
  output logic                   fetch_ready,
  input  wire logic [ADDR_W-1:0] fetch_addr,
  output logic                   entry_valid,
  output logic      [ADDR_W-1:0] entry_data
);
  // ====================================================================
  // memory
  logic [ADDR_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] last;
  int unsigned       wait_n;
  // idle data bus shows the inverse so a stale read cannot pass
  initial begin
    fetch_ready = 1'b0;
    entry_valid = 1'b0;
    entry_data  = ADDR_ZERO;
    last        = ADDR_ZERO;
    forever begin
      @(negedge mclk);
      entry_valid = 1'b0;
      entry_data  = ~last;
      fetch_ready = rst_n && ($urandom_range(0, 2) != 0);
      if (fetch_ready && fetch_valid) begin
        last = mem.exists(fetch_addr) ? mem[fetch_addr] : ~last;
        wait_n = $urandom_range(1, 3);
        @(negedge mclk);
        fetch_ready = 1'b0;
        entry_data  = ~last;
        repeat (wait_n) @(negedge mclk);
        entry_valid = 1'b1;
        entry_data  = last;
      end
    end
  end
endmodule : ppw_host_mem
`default_nettype wire

//--- dv/ppw_walker_tb.sv
// Purpose: random and corner commands through ppw_walker
// Assumes: host model answers fetches
// Notes:   modes 1..4 are error and zero-length corners
`default_nettype none
module ppw_walker_tb
  import ppw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ====================================================================
  // signals
  logic              mclk, rst_n, chk_en, cmd_valid, cmd_ready, seg_valid, seg_ready;
  logic              fetch_valid, fetch_ready, entry_valid, seg_last, done, bad_err;
  logic [MPS_W-1:0]  mps;
  logic [ADDR_W-1:0] p1, p2, fetch_addr, entry_data, seg_addr;
  logic [LEN_W-1:0]  xlen, seg_len;
  ppw_err_t          err_code;
  int                fails, n_compared, cyc;
  logic [95:0]       expq[$];
  ppw_walker DUT (.mclk, .rst_n, .memory_page_size_setting(mps), .check_dword_align(chk_en),
    .cmd_valid, .cmd_ready, .first_command_pointer(p1), .second_command_pointer_slot(p2),
    .xfer_bytes(xlen), .fetch_valid, .fetch_ready, .fetch_addr, .entry_valid, .entry_data,
    .seg_valid, .seg_ready, .seg_addr, .seg_len, .seg_last, .done,
    .bad_page_offset_error(bad_err), .err_code);
  ppw_host_mem u_host (.mclk, .rst_n, .fetch_valid, .fetch_ready, .fetch_addr,
    .entry_valid, .entry_data);
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;
  function automatic logic [ADDR_W-1:0] rnd_page(input logic [ADDR_W-1:0] pg);
    return {$urandom, $urandom} & ~(pg - 64'h1);
  endfunction : rnd_page
  task automatic cmp(input logic [95:0] got, input logic [95:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic conclude();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // one command: build host memory and expected segments, then drain
  task automatic run(input int mode);
    logic [ADDR_W-1:0] pg, a, d, la;
    logic [LEN_W-1:0]  rem, s, pl;
    int                k;
    ppw_err_t          e_err;
    pg = 64'h1 << (PAGE_SHIFT0 + mps);
    pl = pg[31:0];
    e_err = PPW_ERR_NONE;
    la = ADDR_ZERO;
    expq.delete();
    chk_en = (mode == 3) ? 1'b1 : 1'($urandom);
    p1 = rnd_page(pg) | ({32'h0, $urandom} & (pg - 64'h1));
    if (chk_en) p1[1:0] = 2'h0;
    if (mode == 3) p1[1:0] = 2'h2;
    xlen = (mode == 4) ? LEN_ZERO : $urandom_range(1, 5 * pl) + ((mode == 1) ? pl : 0)
      + ((mode == 2) ? 2 * pl : 0);
    rem = xlen;
    s = LEN_W'(pg - (p1 & (pg - 64'h1) & ~64'h3));
    if (rem < s) s = rem;
    if (rem != LEN_ZERO) expq.push_back({p1 & ~64'h3, s});
    rem -= s;
    if (rem > pl) begin
      p2 = rnd_page(pg) + pg - 64'(8 * $urandom_range(1, 4));
      a = p2;
      k = int'((pg - (a & (pg - 64'h1))) >> 3);
      while (rem != LEN_ZERO) begin
        d = rnd_page(pg);
        u_host.mem[a] = d;
        if (k == 1 && rem > pl) begin
          a = d;
          k = int'(pg >> 3);
        end else begin
          s = (rem > pl) ? pl : rem;
          expq.push_back({d, s});
          la = a;
          rem -= s;
          a += 64'h8;
          k--;
        end
      end
    end else begin
      p2 = rnd_page(pg);
      if (rem != LEN_ZERO) expq.push_back({p2, rem});
    end
    if (mode == 1) begin
      if (la != ADDR_ZERO) u_host.mem[la] = u_host.mem[la] | 64'h100;
      else p2 = p2 | 64'h100;
      void'(expq.pop_back());
      e_err = PPW_ERR_BAD_OFFSET;
    end
    if (mode == 2) begin
      p2 = p2 | 64'h4;
      expq = expq[0:0];
      e_err = PPW_ERR_BAD_LIST_PTR;
    end
    if (mode == 3) begin
      expq.delete();
      e_err = PPW_ERR_BAD_OFFSET;
    end
    while (cmd_ready !== 1'b1) @(negedge mclk);
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    while (done !== 1'b1) begin
      seg_ready = ($urandom_range(0, 3) != 0);
      if (seg_valid === 1'b1 && seg_ready) begin
        cmp({seg_addr, seg_len}, expq.size() ? expq[0] : 96'h0);
        if (e_err == PPW_ERR_NONE) cmp(96'(seg_last), 96'(expq.size() == 1));
        if (expq.size() != 0) void'(expq.pop_front());
      end
      @(negedge mclk);
    end
    cmp(96'(expq.size()), 96'h0);
    cmp(96'(bad_err), 96'(e_err != PPW_ERR_NONE));
    cmp(96'(err_code), 96'(e_err));
  endtask : run
  // main sequence: corners first, then random commands
  initial begin
    void'($urandom(32'hF501E5A3));
    {rst_n, cmd_valid, seg_ready, chk_en, mps, p1, p2, xlen} = '0;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    for (int i = 0; i < 40; i++) begin
      mps = MPS_W'($urandom_range(0, 1));
      run((i < 5) ? i : int'($urandom_range(0, 6)));
    end
    conclude();
  end
  // cuts a hang short
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      conclude();
    end
  end
endmodule : ppw_walker_tb
`default_nettype wire
